// [hw/tcs_pkg.sv]
// Package: register map, field positions and reset values of the timer channel
package tcs_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [23:0] ADDR_START   = 24'hff_feb0;
	localparam logic [23:0] ADDR_SYNC    = 24'hff_feb1;
	localparam logic [23:0] ADDR_CLRSEL  = 24'hff_ff10;
	localparam logic [23:0] ADDR_MODE    = 24'hff_ff11;
	localparam logic [23:0] ADDR_IRQ_EN  = 24'hff_ff14;
	localparam logic [23:0] ADDR_STATUS  = 24'hff_ff15;
	localparam logic [23:0] ADDR_COUNTER = 24'hff_ff16;
	localparam logic [23:0] ADDR_CMP_A   = 24'hff_ff18;
	localparam logic [23:0] ADDR_DIR     = 24'hff_ff1a;
	localparam logic [23:0] ADDR_CLEAR   = 24'hff_ff1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_DIR       = 7;
	localparam int BIT_UNDERFLOW = 5;
	localparam int BIT_OVERFLOW  = 4;
	localparam int BIT_MATCH_A   = 0;
	localparam int CLRSEL_LSB    = 5;
	localparam int MODE_RSVD     = 3;
	localparam int DIR_DOWN_BIT  = 0;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  CLR_ON_MATCH_A = 3'h1;
	localparam logic [3:0]  MODE_NORMAL    = 4'h0;
	localparam logic [7:0]  EVENT_MASK     = 8'h31;
	localparam logic [2:0]  RST_RUN        = 3'h0;
	localparam logic [2:0]  RST_SYNC       = 3'h0;
	localparam logic [2:0]  RST_CLRSEL     = 3'h0;
	localparam logic [3:0]  RST_MODE       = 4'h0;
	localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
	localparam logic [7:0]  RST_FLAGS      = 8'h00;
	localparam logic [15:0] RST_COUNTER    = 16'h0000;
	localparam logic [15:0] RST_CMP_A      = 16'hffff;
	localparam logic        RST_DOWN       = 1'b0;

endpackage : tcs_pkg

// [hw/tcs_counter.sv]
// Sixteen-bit up/down channel counter with load, clear and wrap events
`timescale 1ns/1ps

module tcs_counter #(
	parameter int WIDTH = 16
) (
	// Clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	input  wire logic             clr,
	input  wire logic             run,
	input  wire logic             down,
	// State and events
	output logic      [WIDTH-1:0] cnt,
	output logic                  wrap_up,
	output logic                  wrap_dn
);

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;

	assign wrap_up = run && !down && !load && !clr && (cnt_r == {WIDTH{1'b1}});
	assign wrap_dn = run && down && !load && !clr && (cnt_r == {WIDTH{1'b0}});
	assign cnt     = cnt_r;

	// Software load beats clear, clear beats counting
	always_comb begin
		cnt_nxt = cnt_r;
		if (load) begin
			cnt_nxt = load_val;
		end else if (clr) begin
			cnt_nxt = '0;
		end else if (run && down) begin
			cnt_nxt = cnt_r - 1'b1;
		end else if (run) begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : tcs_counter

// [hw/tcs_channel.sv]
// Timer channel 0: registers, status flags, interrupts, start and sync control
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// Summary of operation
// - Status bit 7 reads 1 when counting up, 0 when counting down.
// - Underflow flag, status bit 5, sets on counter underflow.
// - Overflow flag, status bit 4, sets on counter overflow.
// - Match flag A, status bit 0, sets when the running counter equals compare A and is not being written.
// - Sixteen-bit counter readable and writable at FFFF16.
// - Sixteen-bit compare A readable and writable at FFFF18.
// - Start bits 2..0 run their counter when 1, halt it when 0.
// - Sync bits 2..0 make their counter run in step with the others.
// - Underflow request raised only while enable bit 5 is set.
// - Overflow request raised only while its enable bit is set.
// - Match A request raised only while its enable bit is set.
// - Clear select 001 clears the counter on match with compare A.
// - Mode 0000 is normal mode; mode bit 3 is reserved zero.
module tcs_channel #(
	parameter int AW = 24,
	parameter int DW = 16
) (
	// Clock, reset, enable
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          ce,
	// Register port
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [DW-1:0] rdata,
	// Synchronous operation with other channels
	input  wire logic          sync_clear_in,
	output logic               sync_clear_out,
	output logic      [2:0]    counter_run_bit,
	output logic      [2:0]    counter_sync_bit,
	// Interrupts
	output logic               underflow_irq_request,
	output logic               overflow_irq_request,
	output logic               match_a_irq_request,
	output logic               irq
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [AW-1:0] a, input logic [23:0] r);
		hit = (a == AW'(r));
	endfunction : hit

	wire sel_start  = hit(addr, tcs_pkg::ADDR_START);
	wire sel_sync   = hit(addr, tcs_pkg::ADDR_SYNC);
	wire sel_clrsel = hit(addr, tcs_pkg::ADDR_CLRSEL);
	wire sel_mode   = hit(addr, tcs_pkg::ADDR_MODE);
	wire sel_irq_en = hit(addr, tcs_pkg::ADDR_IRQ_EN);
	wire sel_status = hit(addr, tcs_pkg::ADDR_STATUS);
	wire sel_cnt    = hit(addr, tcs_pkg::ADDR_COUNTER);
	wire sel_cmp_a  = hit(addr, tcs_pkg::ADDR_CMP_A);
	wire sel_dir    = hit(addr, tcs_pkg::ADDR_DIR);
	wire sel_clear  = hit(addr, tcs_pkg::ADDR_CLEAR);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [2:0]  run_r;
	logic [2:0]  sync_r;
	logic [2:0]  clrsel_r;
	logic [3:0]  mode_r;
	logic [7:0]  irq_en_r;
	logic [7:0]  flags_r;
	logic [7:0]  flags_nxt;
	logic [15:0] cmp_a_r;
	logic        down_r;
	logic [DW-1:0] rdata_r;
	logic [DW-1:0] rdata_nxt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r    <= tcs_pkg::RST_RUN;
			sync_r   <= tcs_pkg::RST_SYNC;
			clrsel_r <= tcs_pkg::RST_CLRSEL;
			mode_r   <= tcs_pkg::RST_MODE;
			irq_en_r <= tcs_pkg::RST_IRQ_EN;
			cmp_a_r  <= tcs_pkg::RST_CMP_A;
			down_r   <= tcs_pkg::RST_DOWN;
		end else if (ce && wr) begin
			if (sel_start) begin
				run_r <= wdata[2:0];
			end else if (sel_sync) begin
				sync_r <= wdata[2:0];
			end else if (sel_clrsel) begin
				clrsel_r <= wdata[tcs_pkg::CLRSEL_LSB +: 3];
			end else if (sel_mode) begin
				mode_r <= {1'b0, wdata[2:0]};
			end else if (sel_irq_en) begin
				irq_en_r <= wdata[7:0] & tcs_pkg::EVENT_MASK;
			end else if (sel_cmp_a) begin
				cmp_a_r <= wdata[15:0];
			end else if (sel_dir) begin
				down_r <= wdata[tcs_pkg::DIR_DOWN_BIT];
			end
		end
	end

	assign counter_run_bit  = run_r;
	assign counter_sync_bit = sync_r;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic [15:0] cnt;
	logic        wrap_up;
	logic        wrap_dn;

	wire cnt_load  = wr && sel_cnt;
	wire normal    = (mode_r == tcs_pkg::MODE_NORMAL);
	wire match_a   = run_r[0] && !cnt_load && (cnt == cmp_a_r);
	wire clr_match = match_a && (clrsel_r == tcs_pkg::CLR_ON_MATCH_A);
	wire clr_sync  = sync_r[0] && sync_clear_in;
	wire cnt_clr   = clr_match || clr_sync;

	assign sync_clear_out = sync_r[0] && clr_match;

	tcs_counter #(
		.WIDTH (16)
	) u_counter (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.load     (cnt_load),
		.load_val (wdata[15:0]),
		.clr      (cnt_clr),
		.run      (run_r[0]),
		.down     (down_r),
		.cnt      (cnt),
		.wrap_up  (wrap_up),
		.wrap_dn  (wrap_dn)
	);

	// ----------------------------------------------------------------
	// Status flags, set wins over clear
	// ----------------------------------------------------------------
	wire [7:0] set_vec = {2'b00, wrap_dn, wrap_up, 3'b000, match_a};
	wire [7:0] clr_vec = (wr && sel_clear) ? wdata[7:0] : 8'h00;

	assign flags_nxt = ((flags_r & ~clr_vec) | set_vec) & tcs_pkg::EVENT_MASK;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= tcs_pkg::RST_FLAGS;
		end else if (ce) begin
			flags_r <= flags_nxt;
		end
	end

	wire [7:0] status = {!down_r, flags_r[6:0]};

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign underflow_irq_request = flags_r[tcs_pkg::BIT_UNDERFLOW]
		&& irq_en_r[tcs_pkg::BIT_UNDERFLOW];
	assign overflow_irq_request  = flags_r[tcs_pkg::BIT_OVERFLOW]
		&& irq_en_r[tcs_pkg::BIT_OVERFLOW];
	assign match_a_irq_request   = flags_r[tcs_pkg::BIT_MATCH_A]
		&& irq_en_r[tcs_pkg::BIT_MATCH_A];
	assign irq = underflow_irq_request || overflow_irq_request
		|| match_a_irq_request;

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	always_comb begin
		rdata_nxt = '0;
		if (!rd) begin
			rdata_nxt = '0;
		end else if (sel_start) begin
			rdata_nxt = DW'(run_r);
		end else if (sel_sync) begin
			rdata_nxt = DW'(sync_r);
		end else if (sel_clrsel) begin
			rdata_nxt = DW'({clrsel_r, 5'h00});
		end else if (sel_mode) begin
			rdata_nxt = DW'(mode_r);
		end else if (sel_irq_en) begin
			rdata_nxt = DW'(irq_en_r);
		end else if (sel_status) begin
			rdata_nxt = DW'(status);
		end else if (sel_cnt) begin
			rdata_nxt = DW'(cnt);
		end else if (sel_cmp_a) begin
			rdata_nxt = DW'(cmp_a_r);
		end else if (sel_dir) begin
			rdata_nxt = DW'(down_r);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (ce) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wrap_up;
		ce && wrap_up;
	endsequence

	sequence s_wrap_dn;
		ce && wrap_dn;
	endsequence

	sequence s_cnt_write;
		ce && wr && sel_cnt;
	endsequence

	property p_dir;
		ce && wr && sel_dir |=> status[tcs_pkg::BIT_DIR] == !$past(wdata[tcs_pkg::DIR_DOWN_BIT]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction bit wrong");

	property p_underflow;
		s_wrap_dn |=> flags_r[tcs_pkg::BIT_UNDERFLOW] && cnt == 16'hffff;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not flagged");

	property p_overflow;
		s_wrap_up |=> flags_r[tcs_pkg::BIT_OVERFLOW] && cnt == 16'h0000;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	property p_match;
		ce && run_r[0] && !(wr && sel_cnt) && cnt == cmp_a_r
			|=> flags_r[tcs_pkg::BIT_MATCH_A];
	endproperty
	a_match: assert property (p_match) else $error("match flag not set");

	property p_cnt_write;
		s_cnt_write |=> cnt == $past(wdata);
	endproperty
	a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

	property p_cmp_rw;
		ce && wr && sel_cmp_a ##1 ce && rd && sel_cmp_a && !wr |=> rdata == $past(wdata, 2);
	endproperty
	a_cmp_rw: assert property (p_cmp_rw) else $error("compare A readback wrong");

	property p_halt;
		ce && !run_r[0] && !wr && !clr_sync |=> $stable(cnt);
	endproperty
	a_halt: assert property (p_halt) else $error("halted counter moved");

	property p_sync;
		ce && sync_r[0] && sync_clear_in && !(wr && sel_cnt) |=> cnt == 16'h0000;
	endproperty
	a_sync: assert property (p_sync) else $error("sync clear ignored");

	property p_irq_u;
		s_wrap_dn |=> underflow_irq_request == irq_en_r[tcs_pkg::BIT_UNDERFLOW];
	endproperty
	a_irq_u: assert property (p_irq_u) else $error("underflow request wrong");

	property p_irq_v;
		!irq_en_r[tcs_pkg::BIT_OVERFLOW] |-> !overflow_irq_request;
	endproperty
	a_irq_v: assert property (p_irq_v) else $error("overflow request unmasked");

	property p_irq_a;
		flags_r[0] && irq_en_r[0] |-> match_a_irq_request && irq;
	endproperty
	a_irq_a: assert property (p_irq_a) else $error("match A request missing");

	property p_clr_match;
		ce && clr_match && !(wr && sel_cnt) |=> cnt == 16'h0000;
	endproperty
	a_clr_match: assert property (p_clr_match) else $error("match clear missing");

	property p_mode_rsvd;
		!mode_r[tcs_pkg::MODE_RSVD];
	endproperty
	a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bit set");

	property p_sticky;
		flags_r[tcs_pkg::BIT_OVERFLOW] && !(wr && sel_clear) |=> flags_r[tcs_pkg::BIT_OVERFLOW];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped by itself");

endmodule : tcs_channel

// [dv/tcs_tb.sv]
// Testbench for timer channel 0: registers, flags, interrupts, start and sync
`timescale 1ns/1ps

module tb;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        clk;
	logic        nrst;
	logic        ce;
	logic [23:0] addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        sync_clear_in;
	logic        sync_clear_out;
	logic [2:0]  counter_run_bit;
	logic [2:0]  counter_sync_bit;
	logic        underflow_irq_request;
	logic        overflow_irq_request;
	logic        match_a_irq_request;
	logic        irq;
	int          n_fail;
	int          num_checks;

	tcs_channel i_tcs_channel (
		.clk                   (clk),
		.nrst                  (nrst),
		.ce                    (ce),
		.addr                  (addr),
		.wdata                 (wdata),
		.wr                    (wr),
		.rd                    (rd),
		.rdata                 (rdata),
		.sync_clear_in         (sync_clear_in),
		.sync_clear_out        (sync_clear_out),
		.counter_run_bit       (counter_run_bit),
		.counter_sync_bit      (counter_sync_bit),
		.underflow_irq_request (underflow_irq_request),
		.overflow_irq_request  (overflow_irq_request),
		.match_a_irq_request   (match_a_irq_request),
		.irq                   (irq)
	);

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [23:0] a, input logic [15:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input string what, input logic [23:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(what, rdata, exp);
	endtask : rd_chk

	// Start then stop: counter takes k+2 steps
	task automatic run_steps(input int k);
		wr_reg(tcs_pkg::ADDR_START, 16'h0001);
		repeat (k) @(posedge clk);
		wr_reg(tcs_pkg::ADDR_START, 16'h0000);
		#1;
	endtask : run_steps

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_and_regs();
		rd_chk("status", tcs_pkg::ADDR_STATUS, 16'h0080);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'h0000);
		check("irq", {15'h0000, irq}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_START, 16'h0006);
		rd_chk("start", tcs_pkg::ADDR_START, 16'h0006);
		check("run bits", {13'h0000, counter_run_bit}, 16'h0006);
		wr_reg(tcs_pkg::ADDR_SYNC, 16'h0006);
		rd_chk("sync", tcs_pkg::ADDR_SYNC, 16'h0006);
		check("sync bits", {13'h0000, counter_sync_bit}, 16'h0006);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h00ff);
		rd_chk("irq enables", tcs_pkg::ADDR_IRQ_EN, 16'h0031);
		wr_reg(tcs_pkg::ADDR_MODE, 16'h0000);
		rd_chk("mode", tcs_pkg::ADDR_MODE, 16'h0000);
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'habcd);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'habcd);
		wr_reg(tcs_pkg::ADDR_CMP_A, 16'h1234);
		rd_chk("compare a", tcs_pkg::ADDR_CMP_A, 16'h1234);
		// Write then read with no gap between the strobes
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= tcs_pkg::ADDR_CMP_A;
		wdata <= 16'h4321;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("compare a back to back", rdata, 16'h4321);
		wr_reg(tcs_pkg::ADDR_STATUS, 16'h00ff);
		rd_chk("status", tcs_pkg::ADDR_STATUS, 16'h0080);
		wr_reg(24'hff_ff20, 16'h5a5a);
		rd_chk("unmapped", 24'hff_ff20, 16'h0000);
		wr_reg(tcs_pkg::ADDR_START, 16'h0000);
		wr_reg(tcs_pkg::ADDR_SYNC, 16'h0000);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0000);
	endtask : t_reset_and_regs

	task automatic t_count_and_dir();
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'h0010);
		run_steps(5);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'h0017);
		repeat (4) @(posedge clk);
		rd_chk("halted", tcs_pkg::ADDR_COUNTER, 16'h0017);
		wr_reg(tcs_pkg::ADDR_DIR, 16'h0001);
		rd_chk("status down", tcs_pkg::ADDR_STATUS, 16'h0000);
		run_steps(1);
		rd_chk("counter down", tcs_pkg::ADDR_COUNTER, 16'h0014);
		wr_reg(tcs_pkg::ADDR_DIR, 16'h0000);
		// Clock enable low for four edges freezes the running counter
		wr_reg(tcs_pkg::ADDR_START, 16'h0001);
		@(posedge clk);
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		wr_reg(tcs_pkg::ADDR_START, 16'h0000);
		rd_chk("frozen counter", tcs_pkg::ADDR_COUNTER, 16'h0017);
	endtask : t_count_and_dir

	task automatic t_overflow();
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'hfffe);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0010);
		run_steps(0);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'h0000);
		rd_chk("status", tcs_pkg::ADDR_STATUS, 16'h0090);
		check("ovf req", {15'h0000, overflow_irq_request}, 16'h0001);
		check("irq", {15'h0000, irq}, 16'h0001);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0000);
		#1;
		check("ovf req", {15'h0000, overflow_irq_request}, 16'h0000);
		rd_chk("sticky", tcs_pkg::ADDR_STATUS, 16'h0090);
		wr_reg(tcs_pkg::ADDR_CLEAR, 16'h0010);
		rd_chk("cleared", tcs_pkg::ADDR_STATUS, 16'h0080);
	endtask : t_overflow

	task automatic t_underflow();
		wr_reg(tcs_pkg::ADDR_DIR, 16'h0001);
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'h0001);
		run_steps(0);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'hffff);
		rd_chk("status", tcs_pkg::ADDR_STATUS, 16'h0020);
		check("unf masked", {15'h0000, underflow_irq_request}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0020);
		#1;
		check("unf req", {15'h0000, underflow_irq_request}, 16'h0001);
		check("ovf req", {15'h0000, overflow_irq_request}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_CLEAR, 16'h0020);
		#1;
		check("unf req", {15'h0000, underflow_irq_request}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0000);
		wr_reg(tcs_pkg::ADDR_DIR, 16'h0000);
	endtask : t_underflow

	task automatic t_match_clear();
		wr_reg(tcs_pkg::ADDR_CLRSEL, 16'h0020);
		wr_reg(tcs_pkg::ADDR_CMP_A, 16'h0003);
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'h0000);
		run_steps(5);
		rd_chk("counter", tcs_pkg::ADDR_COUNTER, 16'h0003);
		rd_chk("status", tcs_pkg::ADDR_STATUS, 16'h0081);
		check("match masked", {15'h0000, match_a_irq_request}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0001);
		#1;
		check("match req", {15'h0000, match_a_irq_request}, 16'h0001);
		wr_reg(tcs_pkg::ADDR_CLEAR, 16'h0001);
		rd_chk("cleared", tcs_pkg::ADDR_STATUS, 16'h0080);
		check("irq", {15'h0000, irq}, 16'h0000);
		wr_reg(tcs_pkg::ADDR_IRQ_EN, 16'h0000);
		wr_reg(tcs_pkg::ADDR_CLRSEL, 16'h0000);
	endtask : t_match_clear

	task automatic t_sync();
		for (int s = 0; s < 2; s++) begin
			wr_reg(tcs_pkg::ADDR_COUNTER, 16'h0055);
			wr_reg(tcs_pkg::ADDR_SYNC, 16'(s));
			@(posedge clk);
			sync_clear_in <= 1'b1;
			@(posedge clk);
			sync_clear_in <= 1'b0;
			rd_chk("sync clear", tcs_pkg::ADDR_COUNTER, (s == 1) ? 16'h0000 : 16'h0055);
		end
		// Match clear with sync bit set is passed on to the other channels
		wr_reg(tcs_pkg::ADDR_CLRSEL, 16'h0020);
		wr_reg(tcs_pkg::ADDR_CMP_A, 16'h0002);
		wr_reg(tcs_pkg::ADDR_COUNTER, 16'h0000);
		wr_reg(tcs_pkg::ADDR_START, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		check("sync out", {15'h0000, sync_clear_out}, 16'h0001);
		wr_reg(tcs_pkg::ADDR_START, 16'h0000);
		#1;
		check("sync out idle", {15'h0000, sync_clear_out}, 16'h0000);
		rd_chk("sync counter", tcs_pkg::ADDR_COUNTER, 16'h0001);
		wr_reg(tcs_pkg::ADDR_CLEAR, 16'h0001);
		wr_reg(tcs_pkg::ADDR_CLRSEL, 16'h0000);
		wr_reg(tcs_pkg::ADDR_SYNC, 16'h0000);
	endtask : t_sync

	// ----------------------------------------------------------------
	// Clock, reset, sequence, watchdog
	// ----------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		n_fail        = 0;
		num_checks    = 0;
		nrst          = 1'b0;
		ce            = 1'b1;
		addr          = 24'h00_0000;
		wdata         = 16'h0000;
		wr            = 1'b0;
		rd            = 1'b0;
		sync_clear_in = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_and_regs();
		t_count_and_dir();
		t_overflow();
		t_underflow();
		t_match_clear();
		t_sync();
		end_sim();
	end

	initial begin
		#500000;
		n_fail++;
		end_sim();
	end

endmodule : tb
